// ### spim_pkg.sv
// Shared constants and types for the configurable serial master
package spim_pkg;

    // Clock rate and default serial clock rate
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned SCK_HZ_DEF = 1_000_000;

    // Half period of the serial clock in system clock cycles
    localparam logic [15:0] DIV_RST = 16'(CLK_HZ / (2 * SCK_HZ_DEF));
    localparam logic [15:0] DIV_MIN = 16'h0004;

    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_DIV = 8'h04;
    localparam logic [7:0] A_FILL = 8'h08;
    localparam logic [7:0] A_CMD = 8'h0C;
    localparam logic [7:0] A_STAT = 8'h10;
    localparam logic [7:0] A_TX = 8'h14;
    localparam logic [7:0] A_RX = 8'h18;

    // Control register fields
    localparam int C_EN = 0;
    localparam int C_CPOL = 1;
    localparam int C_CPHA = 2;
    localparam int C_LSB = 3;
    localparam int C_WLO = 4;
    localparam int C_WHI = 7;
    localparam int WL_W = 4;
    localparam logic [7:0] CTRL_RST = 8'h70;

    // Fill byte after reset
    localparam logic [7:0] FILL_RST = 8'h00;

    // Command register fields
    localparam int M_LO = 0;
    localparam int M_HI = 1;
    localparam int N_LO = 16;
    localparam int N_HI = 31;

    // Status register fields
    localparam int S_BUSY = 0;
    localparam int S_TXF = 1;
    localparam int S_RXV = 2;
    localparam int S_EN = 3;

    // Bus answers
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    // Transfer kinds, in command encoding order
    typedef enum logic [1:0] {
        SPIM_RD,
        SPIM_WR,
        SPIM_DX
    } spim_mode_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_SHIFT
    } spim_state_t;

endpackage : spim_pkg

// ### spim_shift.sv
// Word shifter that makes the serial clock and moves one word each way
module spim_shift #(
    parameter int MAXW = 16
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic run, // Bus enabled
    input wire logic start, // Begin one word
    input wire logic cpol, // Idle clock level
    input wire logic cpha, // Sample on second edge
    input wire logic lsb, // Least significant bit first
    input wire logic [spim_pkg::WL_W-1:0] wlast, // Word width minus one
    input wire logic [15:0] div, // Half period in cycles
    input wire logic [MAXW-1:0] tx_word, // Word to send
    input wire logic miso, // Synchronised master-in line
    output logic sclk_q, // Serial clock
    output logic mosi_q, // Master-out line
    output logic done_q, // Word finished pulse
    output logic [MAXW-1:0] rx_q // Word received
);

    logic active_q;
    logic [15:0] tmr_q;
    logic [spim_pkg::WL_W:0] edge_q;
    logic [spim_pkg::WL_W-1:0] bit_q;
    logic [MAXW-1:0] txw_q;
    logic lead;
    logic last_edge;

    // Bit position of the n-th bit on the wire
    function automatic logic [spim_pkg::WL_W-1:0] pos(
        input logic [spim_pkg::WL_W-1:0] n,
        input logic lsb_first,
        input logic [spim_pkg::WL_W-1:0] wl
    );
        pos = lsb_first ? n : wl - n;
    endfunction : pos

    assign lead = ~edge_q[0];
    assign last_edge = (edge_q == {wlast, 1'b1});

    // Edge generation, sampling and driving
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            active_q <= 1'b0;
            tmr_q <= 16'h0000;
            edge_q <= '0;
            bit_q <= '0;
            txw_q <= '0;
            rx_q <= '0;
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (!run)
        begin
            // Turned off: no clock, lines parked
            active_q <= 1'b0;
            sclk_q <= cpol;
            mosi_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (!active_q)
            begin
                sclk_q <= cpol;
                if (start)
                begin
                    active_q <= 1'b1;
                    tmr_q <= div - 16'h0001;
                    edge_q <= '0;
                    bit_q <= '0;
                    txw_q <= tx_word;
                    rx_q <= '0;
                    // First bit must be on the line before the first edge
                    if (!cpha)
                    begin
                        mosi_q <= tx_word[pos('0, lsb, wlast)];
                    end
                end
            end
            else if (tmr_q != 16'h0000)
            begin
                tmr_q <= tmr_q - 16'h0001;
            end
            else
            begin
                tmr_q <= div - 16'h0001;
                sclk_q <= ~sclk_q;
                edge_q <= edge_q + 1'b1;
                if (lead ^ cpha)
                begin
                    rx_q[pos(bit_q, lsb, wlast)] <= miso;
                end
                else if (cpha)
                begin
                    mosi_q <= txw_q[pos(bit_q, lsb, wlast)];
                end
                else if (bit_q != wlast)
                begin
                    mosi_q <= txw_q[pos(bit_q + 1'b1, lsb, wlast)];
                end
                if (!lead)
                begin
                    bit_q <= bit_q + 1'b1;
                end
                if (last_edge)
                begin
                    active_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

endmodule : spim_shift

// ### spim_top.sv
// Configurable serial master with an AXI4-Lite register port
module spim_top #(
    parameter int MAXW = 16
) (
    input wire logic aclk, // System clock, 250 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte enables
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write answer
    output logic s_axi_bvalid, // Write answer valid
    input wire logic s_axi_bready, // Write answer ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read answer
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic sclk, // Serial clock
    output logic mosi, // Master-out data
    input wire logic miso, // Master-in data, asynchronous
    output logic busy // Transfer under way
);

    initial
    begin
        if (MAXW < 8 || MAXW > 16)
        begin
            $error("MAXW must lie between 8 and 16");
        end
    end

    // Settings, kept until software changes them
    logic [7:0] ctrl_q;
    logic [15:0] div_q;
    logic [7:0] fill_q;

    // Data holding and sequencing
    logic [MAXW-1:0] tx_q;
    logic tx_full_q;
    logic [MAXW-1:0] rxd_q;
    logic rx_valid_q;
    spim_pkg::spim_state_t state_q;
    spim_pkg::spim_mode_t mode_q;
    logic [15:0] left_q;
    logic start_q;
    logic [MAXW-1:0] word_q;
    logic busy_q;

    // Bus slave state
    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Input synchroniser
    logic miso_s1_q;
    logic miso_s2_q;

    logic wr_fire;
    logic rd_fire;
    logic run;
    logic [spim_pkg::WL_W-1:0] wlast;
    logic cmd_ok;
    logic tx_ok;
    logic cfg_ok;
    logic need_met;
    logic [MAXW-1:0] rx_word;
    logic word_done;
    logic [MAXW-1:0] fill_word;

    assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
    assign rd_fire = s_axi_arvalid & arready_q;
    assign run = ctrl_q[spim_pkg::C_EN];
    assign fill_word = MAXW'(fill_q);

    // Widths beyond the shifter's reach are cut back to the widest it has
    assign wlast = (ctrl_q[spim_pkg::C_WHI:spim_pkg::C_WLO] > spim_pkg::WL_W'(MAXW - 1))
        ? spim_pkg::WL_W'(MAXW - 1) : ctrl_q[spim_pkg::C_WHI:spim_pkg::C_WLO];

    // Which writes the engine will take right now
    assign cmd_ok = run && (state_q == spim_pkg::ST_IDLE) && (wdata_q[spim_pkg::M_HI:spim_pkg::M_LO] != 2'h3);
    assign tx_ok = !tx_full_q;
    assign cfg_ok = (state_q == spim_pkg::ST_IDLE);

    // Word may start once transmit data is there (except for reads) and the last word has been read (except for writes)
    assign need_met = ((mode_q == spim_pkg::SPIM_RD) || tx_full_q)
        && ((mode_q == spim_pkg::SPIM_WR) || !rx_valid_q);

    // Two flops before anything looks at the data-in pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
        end
        else
        begin
            miso_s1_q <= miso;
            miso_s2_q <= miso_s1_q;
        end
    end

    // Write address and data are caught separately, in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && awready_q)
            begin
                aw_hold_q <= 1'b1;
                awready_q <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            else if (wr_fire)
            begin
                aw_hold_q <= 1'b0;
                awready_q <= 1'b1;
            end
            if (s_axi_wvalid && wready_q)
            begin
                w_hold_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            else if (wr_fire)
            begin
                w_hold_q <= 1'b0;
                wready_q <= 1'b1;
            end
        end
    end

    // Write answer: refused DIV, FILL, CMD, TX and unmapped writes get an error; STAT, RX and TX-while-disabled writes are dropped with OK
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= spim_pkg::RESP_OK;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            case (awaddr_q)
                spim_pkg::A_CTRL: bresp_q <= spim_pkg::RESP_OK;
                spim_pkg::A_DIV: bresp_q <= cfg_ok ? spim_pkg::RESP_OK : spim_pkg::RESP_ERR;
                spim_pkg::A_FILL: bresp_q <= cfg_ok ? spim_pkg::RESP_OK : spim_pkg::RESP_ERR;
                spim_pkg::A_CMD: bresp_q <= cmd_ok ? spim_pkg::RESP_OK : spim_pkg::RESP_ERR;
                spim_pkg::A_TX: bresp_q <= tx_ok ? spim_pkg::RESP_OK : spim_pkg::RESP_ERR;
                spim_pkg::A_STAT: bresp_q <= spim_pkg::RESP_OK;
                spim_pkg::A_RX: bresp_q <= spim_pkg::RESP_OK;
                default: bresp_q <= spim_pkg::RESP_ERR;
            endcase
        end
        else if (bvalid_q && s_axi_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // Settings survive a disable; only reset restores the defaults
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q <= spim_pkg::CTRL_RST;
            div_q <= spim_pkg::DIV_RST;
            fill_q <= spim_pkg::FILL_RST;
        end
        else if (wr_fire && wstrb_q[0])
        begin
            if (awaddr_q == spim_pkg::A_CTRL)
            begin
                // While shifting only the enable may change
                if (cfg_ok)
                begin
                    ctrl_q <= wdata_q[7:0];
                end
                else
                begin
                    ctrl_q[spim_pkg::C_EN] <= wdata_q[spim_pkg::C_EN];
                end
            end
            if (awaddr_q == spim_pkg::A_FILL && cfg_ok)
            begin
                fill_q <= wdata_q[7:0];
            end
            // Below the floor the synchroniser delay would eat the setup time
            if (awaddr_q == spim_pkg::A_DIV && cfg_ok)
            begin
                div_q <= (wdata_q[15:0] < spim_pkg::DIV_MIN)
                    ? spim_pkg::DIV_MIN : wdata_q[15:0];
            end
        end
    end

    // Transmit holding word: bus fills it, the sequencer empties it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_q <= '0;
            tx_full_q <= 1'b0;
        end
        else if (!run)
        begin
            tx_full_q <= 1'b0;
        end
        else if (wr_fire && wstrb_q[0] && awaddr_q == spim_pkg::A_TX && tx_ok)
        begin
            tx_q <= wdata_q[MAXW-1:0];
            tx_full_q <= 1'b1;
        end
        else if (state_q == spim_pkg::ST_LOAD && need_met && mode_q != spim_pkg::SPIM_RD)
        begin
            tx_full_q <= 1'b0;
        end
    end

    // Receive holding word; a new word wins over a read in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rxd_q <= '0;
            rx_valid_q <= 1'b0;
        end
        else if (word_done && mode_q != spim_pkg::SPIM_WR && state_q == spim_pkg::ST_SHIFT)
        begin
            rxd_q <= rx_word;
            rx_valid_q <= 1'b1;
        end
        else if (rd_fire && s_axi_araddr == spim_pkg::A_RX)
        begin
            rx_valid_q <= 1'b0;
        end
    end

    // Sequencer: one word at a time until the count runs out
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= spim_pkg::ST_IDLE;
            mode_q <= spim_pkg::SPIM_RD;
            left_q <= 16'h0000;
            start_q <= 1'b0;
            word_q <= '0;
            busy_q <= 1'b0;
        end
        else if (!run)
        begin
            state_q <= spim_pkg::ST_IDLE;
            start_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            start_q <= 1'b0;
            case (state_q)
                spim_pkg::ST_IDLE:
                begin
                    // A zero count is taken and does nothing
                    if (wr_fire && wstrb_q[0] && awaddr_q == spim_pkg::A_CMD && cmd_ok
                        && wdata_q[spim_pkg::N_HI:spim_pkg::N_LO] != 16'h0000)
                    begin
                        mode_q <= spim_pkg::spim_mode_t'(wdata_q[spim_pkg::M_HI:spim_pkg::M_LO]);
                        left_q <= wdata_q[spim_pkg::N_HI:spim_pkg::N_LO];
                        state_q <= spim_pkg::ST_LOAD;
                        busy_q <= 1'b1;
                    end
                end
                spim_pkg::ST_LOAD:
                begin
                    if (need_met)
                    begin
                        word_q <= (mode_q == spim_pkg::SPIM_RD) ? fill_word : tx_q;
                        start_q <= 1'b1;
                        state_q <= spim_pkg::ST_SHIFT;
                    end
                end
                spim_pkg::ST_SHIFT:
                begin
                    if (word_done)
                    begin
                        left_q <= left_q - 16'h0001;
                        if (left_q == 16'h0001)
                        begin
                            state_q <= spim_pkg::ST_IDLE;
                            busy_q <= 1'b0;
                        end
                        else
                        begin
                            state_q <= spim_pkg::ST_LOAD;
                        end
                    end
                end
                default:
                begin
                    state_q <= spim_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Read channel: answer one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= spim_pkg::RESP_OK;
        end
        else if (rd_fire)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= spim_pkg::RESP_OK;
            case (s_axi_araddr)
                spim_pkg::A_CTRL: rdata_q <= {24'h000000, ctrl_q};
                spim_pkg::A_DIV: rdata_q <= {16'h0000, div_q};
                spim_pkg::A_FILL: rdata_q <= {24'h000000, fill_q};
                spim_pkg::A_CMD: rdata_q <= {left_q, 14'h0000, mode_q};
                spim_pkg::A_STAT: rdata_q <= {28'h0000000, run, rx_valid_q, tx_full_q, busy_q};
                spim_pkg::A_TX: rdata_q <= 32'(tx_q);
                spim_pkg::A_RX: rdata_q <= 32'(rxd_q);
                default:
                begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= spim_pkg::RESP_ERR;
                end
            endcase
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Serial engine; no select line is made here, that is left to pins
    spim_shift #(
        .MAXW(MAXW)
    ) u_shift (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run),
        .start(start_q),
        .cpol(ctrl_q[spim_pkg::C_CPOL]),
        .cpha(ctrl_q[spim_pkg::C_CPHA]),
        .lsb(ctrl_q[spim_pkg::C_LSB]),
        .wlast(wlast),
        .div(div_q),
        .tx_word(word_q),
        .miso(miso_s2_q),
        .sclk_q(sclk),
        .mosi_q(mosi),
        .done_q(word_done),
        .rx_q(rx_word)
    );

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign busy = busy_q;

endmodule : spim_top

// ### spim_monitor.sv
// Port-level checker for the configurable serial master
module spim_monitor (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic s_axi_awvalid, // Address valid
    input wire logic s_axi_awready, // Address ready
    input wire logic s_axi_wvalid, // Data valid
    input wire logic s_axi_wready, // Data ready
    input wire logic [1:0] s_axi_bresp, // Write answer
    input wire logic s_axi_bvalid, // Answer valid
    input wire logic s_axi_bready, // Answer ready
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic [1:0] s_axi_rresp, // Read answer
    input wire logic s_axi_rvalid, // Read valid
    input wire logic s_axi_rready, // Read ready
    input wire logic sclk, // Serial clock
    input wire logic mosi, // Master-out
    input wire logic busy // Transfer flag
);
    default clocking mon_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Lines parked and no write answer pending right after reset
    rst_quiet_a: assert property ($rose(aresetn) |-> !busy && !sclk && !mosi && !s_axi_bvalid)
        else $error("outputs not quiet after reset");
    // Clock moves only while shifting or one cycle after a setting write lands
    idle_clock_a: assert property (!$rose(s_axi_bvalid) |=> busy || $stable(sclk))
        else $error("serial clock moved while idle");
    // Divider floor of four cycles keeps each half period
    half_period_a: assert property (busy && $changed(sclk) |=> $stable(sclk)[*3])
        else $error("serial clock half period too short");
    busy_start_a: assert property ($rose(busy) |-> s_axi_bvalid && s_axi_bresp == spim_pkg::RESP_OK)
        else $error("busy rose without an accepted command");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid) else $error("write answer late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == spim_pkg::RESP_ERR |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
endmodule : spim_monitor

bind spim_top spim_monitor spim_monitor_i (.*);

// ### spim_periph.sv
// Behavioural serial peripheral facing the master
module spim_periph (
    input wire logic sclk, // Serial clock
    input wire logic mosi, // Master-out
    input wire logic sel_n, // Select from outside pins
    input wire logic [2:0] cfg, // Lsb-first, phase, polarity
    input wire logic [7:0] tx_byte, // Byte to return
    output logic miso = 1'b0, // Master-in
    output logic [7:0] rx_byte // Byte captured
);
    timeunit 1ns;
    timeprecision 1ps;
    int idx;
    // Phase 0 puts the first bit out on select
    always @(negedge sel_n)
    begin
        idx = cfg[1] ? 0 : 1;
        if (!cfg[1]) miso = cfg[2] ? tx_byte[0] : tx_byte[7];
    end
    // A released line shows no held value
    always @(posedge sel_n) miso = ~miso;
    // Sample on one edge of each bit, launch on the other
    always @(sclk)
        if (!sel_n)
        begin
            if ((sclk != cfg[0]) != cfg[1])
                rx_byte = cfg[2] ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
            else if (idx < 8)
            begin
                miso = cfg[2] ? tx_byte[idx] : tx_byte[7 - idx];
                idx = idx + 1;
            end
        end
endmodule : spim_periph

// ### tb_top.sv
// Self-checking bench for the configurable serial master
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sel_n = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic sclk, mosi, miso, busy, aw, w;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, m;
    logic [31:0] s_axi_rdata, seed = 32'h48A4, d, cfg;
    logic [7:0] tx, fill, p_tx, p_rx;
    int n_errors = 0, checks_done = 0;

    spim_top spim_top_i (.*);
    spim_periph spim_periph_i (.sclk(sclk), .mosi(mosi), .sel_n(sel_n), .cfg(cfg[2:0]),
        .tx_byte(p_tx), .miso(miso), .rx_byte(p_rx));

    // Free-running system clock
    initial
        forever #2 aclk = ~aclk;

    function automatic logic [31:0] nxt();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : nxt

    // Read sends the fill byte, the other kinds the supplied byte
    function automatic logic [31:0] exp_sent(logic [1:0] k, logic [7:0] t, logic [7:0] f);
        return {24'h0, k == 2'h0 ? f : t};
    endfunction : exp_sent

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Each channel is released at the edge that takes it
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        {aw, w} = 2'b11;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
        end
        while (aw || w);
        while (!s_axi_bvalid) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    // Hang guard, far beyond the expected run
    initial
    begin
        repeat (30000) @(posedge aclk);
        n_errors++;
        wrap_up();
    end

    // Main sequence: reset values, twelve transfers cycling the three kinds under random settings, abort
    initial
    begin
        cfg = 32'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(spim_pkg::A_CTRL);
        chk("ctrl reset", d, 32'h70);
        axi_rd(spim_pkg::A_DIV);
        chk("div reset", d, spim_pkg::CLK_HZ / (2 * 1000000));
        axi_rd(spim_pkg::A_FILL);
        chk("fill reset", d, 32'h0);
        axi_rd(8'h1C);
        chk("unmapped", {30'h0, r}, {30'h0, spim_pkg::RESP_ERR});
        axi_wr(spim_pkg::A_CMD, 32'h10001);
        chk("cmd disabled", {30'h0, r}, {30'h0, spim_pkg::RESP_ERR});
        axi_wr(spim_pkg::A_DIV, 32'h6);
        for (int k = 0; k < 12; k++)
        begin
            cfg = nxt();
            m = 2'(k % 3);
            tx = 8'(nxt());
            fill = 8'(nxt());
            p_tx = 8'(nxt());
            axi_wr(spim_pkg::A_CTRL, {24'h0, 4'h7, cfg[2:0], 1'b1});
            // Clock level follows the setting one edge after the write lands
            axi_wr(spim_pkg::A_FILL, {24'h0, fill});
            chk("sclk idle", {31'h0, sclk}, {31'h0, cfg[0]});
            if (m != 2'h0) axi_wr(spim_pkg::A_TX, {24'h0, tx});
            sel_n = 1'b0;
            axi_wr(spim_pkg::A_CMD, {16'h1, 14'h0, m});
            chk("cmd", {30'h0, r}, {30'h0, spim_pkg::RESP_OK});
            if (k == 0) axi_wr(spim_pkg::A_CMD, {16'h1, 14'h0, m});
            if (k == 0) chk("cmd busy", {30'h0, r}, {30'h0, spim_pkg::RESP_ERR});
            while (busy) @(posedge aclk);
            sel_n = 1'b1;
            chk("peer rx", {24'h0, p_rx}, exp_sent(m, tx, fill));
            axi_rd(m == 2'h1 ? spim_pkg::A_STAT : spim_pkg::A_RX);
            chk("rx", m == 2'h1 ? {31'h0, d[2]} : d, m == 2'h1 ? 32'h0 : {24'h0, p_tx});
        end
        // Mode code 3 names no transfer kind and is refused
        axi_wr(spim_pkg::A_CMD, {16'h1, 14'h0, 2'h3});
        chk("cmd mode", {30'h0, r}, {30'h0, spim_pkg::RESP_ERR});
        axi_wr(spim_pkg::A_TX, {24'h0, tx});
        sel_n = 1'b0;
        axi_wr(spim_pkg::A_CMD, {16'h2, 14'h0, 2'h2});
        do axi_rd(spim_pkg::A_STAT); while (d[2] !== 1'b1);
        axi_wr(spim_pkg::A_CTRL, {24'h0, 4'h7, cfg[2:0], 1'b0});
        // Lines and busy drop one edge after the enable clears
        @(posedge aclk);
        chk("abort busy", {31'h0, busy}, 32'h0);
        chk("abort lines", {30'h0, sclk, mosi}, {30'h0, cfg[0], 1'b0});
        axi_rd(spim_pkg::A_CTRL);
        chk("ctrl kept", d, {24'h0, 4'h7, cfg[2:0], 1'b0});
        sel_n = 1'b1;
        wrap_up();
    end
endmodule : tb_top
